// ==== logic/dbirq_pkg.sv ====
// Package of constants for the doorbell interrupt set and clear-gate block
package dbirq_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned EVT_W  = 4;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFF_REQ_CLR  = 8'h70;
  localparam logic [ADDR_W-1:0] OFF_REQ_SET  = 8'h74;
  localparam logic [ADDR_W-1:0] OFF_GATE_CLR = 8'h78;
  localparam logic [ADDR_W-1:0] OFF_EVT_STAT = 8'h80;
  localparam logic [ADDR_W-1:0] OFF_EVT_EN   = 8'h84;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned PRI_LSB     = 0;
  localparam int unsigned SEC_LSB     = 16;
  localparam int unsigned EVT_PRI_SET = 0;
  localparam int unsigned EVT_SEC_SET = 1;
  localparam int unsigned EVT_PRI_BLK = 2;
  localparam int unsigned EVT_SEC_BLK = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [HALF_W-1:0] REQ_RST      = 16'h0000;
  localparam logic [HALF_W-1:0] GATE_RST     = 16'hffff;
  localparam logic [EVT_W-1:0]  EVT_STAT_RST = 4'h0;
  localparam logic [EVT_W-1:0]  EVT_EN_RST   = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RST    = 32'h0000_0000;

endpackage

// ==== logic/dbirq_bank.sv ====
// One side's request bits and clear-gate mask bits
`timescale 1ns/10ps
module dbirq_bank #(
  parameter int unsigned W = dbirq_pkg::HALF_W
) (
  input  wire logic         pclk,        // Core clock
  input  wire logic         presetn,     // Async reset, active low
  input  wire logic         set_wr,      // Write strobe to request-set port
  input  wire logic         clr_wr,      // Write strobe to request-clear port
  input  wire logic         gate_clr_wr, // Write strobe to gate-clear port
  input  wire logic [W-1:0] wdata,       // This side's half of write data
  output logic      [W-1:0] req_q,       // Request bits
  output logic      [W-1:0] gate_q,      // Clear-gate mask bits
  output logic              set_evt,     // A request bit newly set
  output logic              blk_evt      // A clear attempt was gated off
);
  import dbirq_pkg::*;

  typedef struct packed {
    logic [W-1:0] req;
    logic [W-1:0] gate;
  } dbirq_bank_s;

  dbirq_bank_s  st_q;
  dbirq_bank_s  st_d;
  logic [W-1:0] req_nx;
  logic [W-1:0] gate_nx;
  logic [W-1:0] newly;
  logic [W-1:0] blk;

  // ****************************************************************
  // Per-bit next state
  // ****************************************************************
  // Set beats clear; a zero in wdata leaves its bit alone
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign req_nx[i]  = (set_wr & wdata[i]) |
                        (st_q.req[i] & ~(clr_wr & wdata[i] & ~st_q.gate[i]));
    assign gate_nx[i] = st_q.gate[i] & ~(gate_clr_wr & wdata[i]);
    assign newly[i]   = set_wr & wdata[i] & ~st_q.req[i];
    assign blk[i]     = clr_wr & wdata[i] & st_q.gate[i] & st_q.req[i];
  end

  // Fill next state
  always_comb begin
    st_d      = st_q;
    st_d.req  = req_nx;
    st_d.gate = gate_nx;
  end

  // Register state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.req  <= REQ_RST;
      st_q.gate <= GATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign req_q   = st_q.req;
  assign gate_q  = st_q.gate;
  assign set_evt = |newly;
  assign blk_evt = |blk;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_set_ones;
    @(posedge pclk) disable iff (!presetn)
    set_wr |=> ((req_q & $past(wdata)) == $past(wdata));
  endproperty
  a_set_ones: assert property (p_set_ones) else $error("set write missed a bit");

  property p_zero_hold;
    @(posedge pclk) disable iff (!presetn)
    set_wr |=> ((req_q & ~$past(wdata)) == ($past(req_q) & ~$past(wdata)));
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero bit changed on set");

  property p_gate_clr;
    @(posedge pclk) disable iff (!presetn)
    gate_clr_wr |=> ((gate_q & $past(wdata)) == '0);
  endproperty
  a_gate_clr: assert property (p_gate_clr) else $error("gate bit not cleared");

  property p_gate_no_rise;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((gate_q & ~$past(gate_q)) == '0);
  endproperty
  a_gate_no_rise: assert property (p_gate_no_rise) else $error("gate bit rose");

  property p_clr_blocked;
    @(posedge pclk) disable iff (!presetn)
    clr_wr |=> ((req_q & $past(gate_q)) == ($past(req_q) & $past(gate_q)));
  endproperty
  a_clr_blocked: assert property (p_clr_blocked) else $error("gated request cleared");

  property p_clr_allowed;
    @(posedge pclk) disable iff (!presetn)
    (clr_wr && !set_wr) |=> ((req_q & $past(wdata) & ~$past(gate_q)) == '0);
  endproperty
  a_clr_allowed: assert property (p_clr_allowed) else $error("ungated request kept");

endmodule

// ==== logic/dbirq_top.sv ====
// Doorbell request set, request clear and clear-gate registers on APB
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
module dbirq_top (
  input  wire logic                         pclk,     // Core clock, 250 MHz
  input  wire logic                         presetn,  // Async reset, active low
  input  wire logic                         psel,     // APB select
  input  wire logic                         penable,  // APB access phase
  input  wire logic                         pwrite,   // APB direction, 1 = write
  input  wire logic [dbirq_pkg::ADDR_W-1:0] paddr,    // APB byte address
  input  wire logic [dbirq_pkg::DATA_W-1:0] pwdata,   // APB write data
  output logic      [dbirq_pkg::DATA_W-1:0] prdata,   // APB read data
  output logic                              pready,   // APB ready
  output logic                              pslverr,  // APB error, unmapped
  output logic                              pri_req,  // Primary request pending
  output logic                              sec_req,  // Secondary request pending
  output logic                              irq       // Event interrupt, level
);
  import dbirq_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              ready;
    logic              err;
    logic [EVT_W-1:0]  stat;
    logic [EVT_W-1:0]  en;
    logic              irq;
    logic              pri;
    logic              sec;
  } dbirq_top_s;

  dbirq_top_s        st_q;
  dbirq_top_s        st_d;
  logic              wr_go;
  logic              rd_go;
  logic              hit;
  logic [HALF_W-1:0] pri_req_b;
  logic [HALF_W-1:0] pri_gate_b;
  logic [HALF_W-1:0] sec_req_b;
  logic [HALF_W-1:0] sec_gate_b;
  logic              pri_set_evt;
  logic              pri_blk_evt;
  logic              sec_set_evt;
  logic              sec_blk_evt;
  logic [EVT_W-1:0]  evt;
  logic [DATA_W-1:0] rd_mux;
  logic [HALF_W-1:0] pri_wd;
  logic [HALF_W-1:0] sec_wd;
  logic [EVT_W-1:0]  evt_wd;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // Write takes effect at the edge where pready is seen high
  assign wr_go = psel & penable & st_q.ready & pwrite;
  assign rd_go = psel & penable & ~st_q.ready;
  assign hit   = (paddr == OFF_REQ_CLR) | (paddr == OFF_REQ_SET) |
                 (paddr == OFF_GATE_CLR) | (paddr == OFF_EVT_STAT) |
                 (paddr == OFF_EVT_EN);

  // Each side's half of the write word, and the event field
  assign pri_wd = pwdata[PRI_LSB +: HALF_W];
  assign sec_wd = pwdata[SEC_LSB +: HALF_W];
  assign evt_wd = pwdata[EVT_W-1:0];

  // ****************************************************************
  // Primary and secondary banks, each owning its half of the word
  // ****************************************************************
  dbirq_bank #(.W(HALF_W)) u_pri (
    .pclk        (pclk),
    .presetn     (presetn),
    .set_wr      (wr_go & (paddr == OFF_REQ_SET)),
    .clr_wr      (wr_go & (paddr == OFF_REQ_CLR)),
    .gate_clr_wr (wr_go & (paddr == OFF_GATE_CLR)),
    .wdata       (pri_wd),
    .req_q       (pri_req_b),
    .gate_q      (pri_gate_b),
    .set_evt     (pri_set_evt),
    .blk_evt     (pri_blk_evt)
  );

  dbirq_bank #(.W(HALF_W)) u_sec (
    .pclk        (pclk),
    .presetn     (presetn),
    .set_wr      (wr_go & (paddr == OFF_REQ_SET)),
    .clr_wr      (wr_go & (paddr == OFF_REQ_CLR)),
    .gate_clr_wr (wr_go & (paddr == OFF_GATE_CLR)),
    .wdata       (sec_wd),
    .req_q       (sec_req_b),
    .gate_q      (sec_gate_b),
    .set_evt     (sec_set_evt),
    .blk_evt     (sec_blk_evt)
  );

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always_comb begin
    rd_mux = RDATA_RST;
    case (paddr)
      OFF_REQ_CLR,
      OFF_REQ_SET:  rd_mux = {sec_req_b, pri_req_b};
      OFF_GATE_CLR: rd_mux = {sec_gate_b, pri_gate_b};
      OFF_EVT_STAT: rd_mux[EVT_W-1:0] = st_q.stat;
      OFF_EVT_EN:   rd_mux[EVT_W-1:0] = st_q.en;
      default:      rd_mux = RDATA_RST;
    endcase
  end

  assign evt[EVT_PRI_SET] = pri_set_evt;
  assign evt[EVT_SEC_SET] = sec_set_evt;
  assign evt[EVT_PRI_BLK] = pri_blk_evt;
  assign evt[EVT_SEC_BLK] = sec_blk_evt;

  // ****************************************************************
  // Next state: bus answer, event status, interrupt
  // ****************************************************************
  always_comb begin
    st_d       = st_q;
    st_d.ready = rd_go;
    if (rd_go) begin
      st_d.err   = ~hit;
      st_d.rdata = pwrite ? RDATA_RST : rd_mux;
    end
    // Sticky status: a new event beats a same-cycle clear
    if (wr_go && (paddr == OFF_EVT_STAT)) begin
      st_d.stat = st_q.stat & ~evt_wd;
    end
    st_d.stat = st_d.stat | evt;
    if (wr_go && (paddr == OFF_EVT_EN)) begin
      st_d.en = evt_wd;
    end
    st_d.irq = |(st_q.stat & st_q.en);
    st_d.pri = |pri_req_b;
    st_d.sec = |sec_req_b;
  end

  // Register state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.rdata <= RDATA_RST;
      st_q.ready <= 1'b0;
      st_q.err   <= 1'b0;
      st_q.stat  <= EVT_STAT_RST;
      st_q.en    <= EVT_EN_RST;
      st_q.irq   <= 1'b0;
      st_q.pri   <= 1'b0;
      st_q.sec   <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata  = st_q.rdata;
  assign pready  = st_q.ready;
  assign pslverr = st_q.err;
  assign irq     = st_q.irq;
  assign pri_req = st_q.pri;
  assign sec_req = st_q.sec;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_rd_req;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && (paddr == OFF_REQ_SET))
      |-> (prdata == {sec_req_b, pri_req_b});
  endproperty
  a_rd_req: assert property (p_rd_req) else $error("request read mismatch");

  property p_rd_gate;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && (paddr == OFF_GATE_CLR))
      |-> (prdata == {sec_gate_b, pri_gate_b});
  endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("gate read mismatch");

  property p_rd_clr_port;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && (paddr == OFF_REQ_CLR))
      |-> (prdata == {sec_req_b, pri_req_b});
  endproperty
  a_rd_clr_port: assert property (p_rd_clr_port) else $error("clear-port read mismatch");

  // ****************************************************************
  // Checks on the bus answer
  // ****************************************************************
  property p_rdy_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held too long");

  property p_rdy_cause;
    @(posedge pclk) disable iff (!presetn)
    pready |-> ($past(psel) && $past(penable));
  endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready without access");

  property p_rdy_in_xfer;
    @(posedge pclk) disable iff (!presetn)
    pready |-> (psel && penable);
  endproperty
  a_rdy_in_xfer: assert property (p_rdy_in_xfer) else $error("ready outside transfer");

  property p_idle_no_rdy;
    @(posedge pclk) disable iff (!presetn)
    !psel |=> !pready;
  endproperty
  a_idle_no_rdy: assert property (p_idle_no_rdy) else $error("ready from idle bus");

  property p_err_map;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready) |-> (pslverr == !hit);
  endproperty
  a_err_map: assert property (p_err_map) else $error("error flag wrong");

  property p_wr_zero;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite) |-> (prdata == '0);
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write answer not zero");

  property p_unmap_zero;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !hit) |-> (prdata == '0);
  endproperty
  a_unmap_zero: assert property (p_unmap_zero) else $error("unmapped answer not zero");

  // ****************************************************************
  // Checks on register effects
  // ****************************************************************
  property p_pri_set;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && (paddr == OFF_REQ_SET)) |=> ((pri_req_b & $past(pri_wd)) == $past(pri_wd));
  endproperty
  a_pri_set: assert property (p_pri_set) else $error("primary set missed");

  property p_sec_set;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && (paddr == OFF_REQ_SET)) |=> ((sec_req_b & $past(sec_wd)) == $past(sec_wd));
  endproperty
  a_sec_set: assert property (p_sec_set) else $error("secondary set missed");

  property p_pri_indep;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && (paddr == OFF_REQ_SET) && (pri_wd == '0)) |=> $stable(pri_req_b);
  endproperty
  a_pri_indep: assert property (p_pri_indep) else $error("primary half disturbed");

  property p_sec_indep;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && (paddr == OFF_REQ_SET) && (sec_wd == '0)) |=> $stable(sec_req_b);
  endproperty
  a_sec_indep: assert property (p_sec_indep) else $error("secondary half disturbed");

  property p_pri_gate_clr;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && (paddr == OFF_GATE_CLR)) |=> ((pri_gate_b & $past(pri_wd)) == '0);
  endproperty
  a_pri_gate_clr: assert property (p_pri_gate_clr) else $error("primary gate kept");

  property p_sec_gate_clr;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && (paddr == OFF_GATE_CLR)) |=> ((sec_gate_b & $past(sec_wd)) == '0);
  endproperty
  a_sec_gate_clr: assert property (p_sec_gate_clr) else $error("secondary gate kept");

  property p_pri_clr_ok;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && (paddr == OFF_REQ_CLR))
      |=> ((pri_req_b & $past(pri_wd) & ~$past(pri_gate_b)) == '0);
  endproperty
  a_pri_clr_ok: assert property (p_pri_clr_ok) else $error("primary clear missed");

  property p_sec_clr_ok;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && (paddr == OFF_REQ_CLR))
      |=> ((sec_req_b & $past(sec_wd) & ~$past(sec_gate_b)) == '0);
  endproperty
  a_sec_clr_ok: assert property (p_sec_clr_ok) else $error("secondary clear missed");

  property p_pri_clr_gated;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && (paddr == OFF_REQ_CLR))
      |=> ((pri_req_b & $past(pri_gate_b)) == ($past(pri_req_b) & $past(pri_gate_b)));
  endproperty
  a_pri_clr_gated: assert property (p_pri_clr_gated) else $error("primary gate ignored");

  property p_sec_clr_gated;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && (paddr == OFF_REQ_CLR))
      |=> ((sec_req_b & $past(sec_gate_b)) == ($past(sec_req_b) & $past(sec_gate_b)));
  endproperty
  a_sec_clr_gated: assert property (p_sec_clr_gated) else $error("secondary gate ignored");

  property p_unmap_wr;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && !hit) |=> ($stable(pri_req_b) && $stable(sec_req_b) &&
                         $stable(pri_gate_b) && $stable(sec_gate_b) && $stable(st_q.en));
  endproperty
  a_unmap_wr: assert property (p_unmap_wr) else $error("unmapped write took effect");

  property p_rd_no_change;
    @(posedge pclk) disable iff (!presetn)
    (psel && !pwrite) |=> ($stable(pri_req_b) && $stable(sec_req_b) &&
                           $stable(pri_gate_b) && $stable(sec_gate_b));
  endproperty
  a_rd_no_change: assert property (p_rd_no_change) else $error("read changed state");

  // ****************************************************************
  // Checks on events and outputs
  // ****************************************************************
  property p_pri_out;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (pri_req == ($past(pri_req_b) != '0));
  endproperty
  a_pri_out: assert property (p_pri_out) else $error("primary pending wrong");

  property p_sec_out;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (sec_req == ($past(sec_req_b) != '0));
  endproperty
  a_sec_out: assert property (p_sec_out) else $error("secondary pending wrong");

  property p_stat_sticky;
    @(posedge pclk) disable iff (!presetn)
    !(wr_go && (paddr == OFF_EVT_STAT))
      |=> ((st_q.stat & $past(st_q.stat)) == $past(st_q.stat));
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status bit dropped");

  property p_stat_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (evt != '0) |=> ((st_q.stat & $past(evt)) == $past(evt));
  endproperty
  a_stat_set_wins: assert property (p_stat_set_wins) else $error("event not recorded");

  property p_en_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && (paddr == OFF_EVT_EN)) |=> (st_q.en == $past(evt_wd));
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (irq == (($past(st_q.stat) & $past(st_q.en)) != '0));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  property p_irq_en;
    @(posedge pclk) disable iff (!presetn)
    irq |-> ($past(st_q.en) != '0);
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("interrupt while disabled");

endmodule

// ==== bench/dbirq_apb_master.sv ====
// Bus master on the register port, driving one APB transfer at a time
`timescale 1ns/10ps
module dbirq_apb_master (
  input  wire logic        pclk,    // Core clock
  output logic             psel,    // APB select
  output logic             penable, // APB access phase
  output logic             pwrite,  // APB direction
  output logic [7:0]       paddr,   // APB byte address
  output logic [31:0]      pwdata,  // APB write data
  input  wire logic [31:0] prdata,  // APB read data
  input  wire logic        pready,  // APB ready
  input  wire logic        pslverr  // APB error
);
  // ************************************************************
  // Transfer task
  // ************************************************************
  // Idle bus at time zero
  initial begin
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 8'h00;
    pwdata  <= 32'h0000_0000;
  end

  // Request is held until pready is seen high or 64 cycles pass, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er, output logic to);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    to      = (pready !== 1'b1);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the doorbell request and clear-gate registers
`timescale 1ns/10ps
module testbench;
  import dbirq_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              psel, penable, pwrite, pready, pslverr;
  logic              pri_req, sec_req, irq;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  int                errors, checks_done;

  dbirq_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pri_req(pri_req), .sec_req(sec_req), .irq(irq));
  dbirq_apb_master i_master (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One transfer, checking error flag and, for reads, the data
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic eerr);
    logic [31:0] rd;
    logic        er, to;
    i_master.xfer(w, a, d, rd, er, to);
    if (to) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      final_report();
    end else begin
      chk({31'h0, er}, {31'h0, eerr});
      if (!w) chk(rd, d);
    end
  endtask

  task automatic pins(input logic [2:0] exp);
    repeat (3) @(posedge pclk);
    chk({29'h0, pri_req, sec_req, irq}, {29'h0, exp});
  endtask

  // Clock at 250 MHz
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    errors      = 0;
    checks_done = 0;
    presetn     = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    pins(3'b000);
    acc(1'b0, OFF_REQ_SET, 32'h0000_0000, 1'b0);
    acc(1'b0, OFF_GATE_CLR, 32'hffff_ffff, 1'b0);
    $display("test reset done");
    acc(1'b1, OFF_REQ_SET, 32'h0000_00a5, 1'b0);
    acc(1'b0, OFF_REQ_SET, 32'h0000_00a5, 1'b0);
    pins(3'b100);
    acc(1'b1, OFF_REQ_SET, 32'h5a00_0000, 1'b0);
    acc(1'b0, OFF_REQ_SET, 32'h5a00_00a5, 1'b0);
    pins(3'b110);
    $display("test set done");
    acc(1'b1, OFF_REQ_CLR, 32'hffff_ffff, 1'b0);
    acc(1'b0, OFF_REQ_CLR, 32'h5a00_00a5, 1'b0);
    acc(1'b1, OFF_GATE_CLR, 32'h0000_0001, 1'b0);
    acc(1'b0, OFF_GATE_CLR, 32'hffff_fffe, 1'b0);
    acc(1'b1, OFF_GATE_CLR, 32'h0200_0000, 1'b0);
    acc(1'b0, OFF_GATE_CLR, 32'hfdff_fffe, 1'b0);
    acc(1'b1, OFF_REQ_CLR, 32'hffff_ffff, 1'b0);
    acc(1'b0, OFF_REQ_SET, 32'h5800_00a4, 1'b0);
    $display("test gate done");
    acc(1'b0, 8'h7c, 32'h0000_0000, 1'b1);
    acc(1'b1, 8'h75, 32'hffff_ffff, 1'b1);
    acc(1'b0, OFF_REQ_SET, 32'h5800_00a4, 1'b0);
    $display("test unmapped done");
    acc(1'b0, OFF_EVT_STAT, 32'h0000_000f, 1'b0);
    acc(1'b1, OFF_EVT_EN, 32'h0000_0001, 1'b0);
    pins(3'b111);
    acc(1'b1, OFF_EVT_EN, 32'h0000_0000, 1'b0);
    pins(3'b110);
    acc(1'b1, OFF_EVT_EN, 32'h0000_000f, 1'b0);
    acc(1'b1, OFF_EVT_STAT, 32'h0000_000f, 1'b0);
    pins(3'b110);
    acc(1'b0, OFF_EVT_STAT, 32'h0000_0000, 1'b0);
    $display("test interrupt done");
    acc(1'b1, OFF_GATE_CLR, 32'hffff_ffff, 1'b0);
    acc(1'b0, OFF_GATE_CLR, 32'h0000_0000, 1'b0);
    acc(1'b1, OFF_REQ_CLR, 32'hffff_ffff, 1'b0);
    acc(1'b0, OFF_REQ_CLR, 32'h0000_0000, 1'b0);
    pins(3'b000);
    acc(1'b1, OFF_REQ_SET, 32'h0001_0001, 1'b0);
    pins(3'b111);
    acc(1'b1, OFF_EVT_STAT, 32'h0000_000f, 1'b0);
    acc(1'b1, OFF_REQ_SET, 32'h0001_0001, 1'b0);
    acc(1'b0, OFF_EVT_STAT, 32'h0000_0000, 1'b0);
    acc(1'b0, OFF_REQ_SET, 32'h0001_0001, 1'b0);
    pins(3'b110);
    $display("test clear done");
    // Second reset in mid-run brings every register back
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    pins(3'b000);
    acc(1'b0, OFF_REQ_SET, 32'h0000_0000, 1'b0);
    acc(1'b0, OFF_GATE_CLR, 32'hffff_ffff, 1'b0);
    acc(1'b0, OFF_EVT_EN, 32'h0000_0000, 1'b0);
    $display("test second reset done");
    final_report();
  end
endmodule
